// ==== logic/seefe_defs.svh ====
`ifndef SEEFE_DEFS_SVH
`define SEEFE_DEFS_SVH
// Fixed memory type code carried in the top nibble of the address word
`define SEEFE_TYPE_CODE 4'hA
// Array shape: 256 pages of 32 bytes, 13-bit word address
`define SEEFE_ADDR_W 13
`define SEEFE_PAGE_BITS 5
`define SEEFE_MEM_DEPTH 8192
// Self-timed write cycle, longest time, in ns and in sys_clk cycles
`define SEEFE_TWR_NS 5000000
`define SEEFE_CLK_NS 4
`define SEEFE_TWR_CYC (`SEEFE_TWR_NS / `SEEFE_CLK_NS)
// Controller link clock divider: quarter period in sys_clk cycles
`define SEEFE_HALF_DIV 6
// Buffer depth on the controller side
`define SEEFE_FIFO_DEPTH 32
`endif

// ==== logic/seefe_pkg.sv ====
package seefe_pkg;
   typedef enum logic [1:0] {SEEFE_OP_WRITE, SEEFE_OP_READ, SEEFE_OP_SETADDR} seefe_op_t;
   typedef struct packed {
      logic last;
      logic [7:0] data;
   } seefe_word_t;
endpackage

// ==== logic/seefe_if.sv ====
`timescale 1ns/1ps
interface seefe_if;
   logic scl_o;
   logic scl_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic sda_ctl_o;
   logic sda_ctl_oe;
   logic scl;
   logic sda;
   // Open-drain wire: any enabled driver pulls low, else the pull-up wins
   assign scl = ~(scl_oe & ~scl_o);
   assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_ctl_oe & ~sda_ctl_o));
   modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
   modport ctl (input scl, input sda, output scl_o, output scl_oe, output sda_ctl_o,
      output sda_ctl_oe);
endinterface

// ==== logic/seefe_fifo.sv ====
`timescale 1ns/1ps
module seefe_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   // Honest flags straight from the fill count
   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rp_r];

   // Storage write
   always_ff @(posedge sys_clk)
   begin
      if (push)
      begin
         mem[wp_r] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop)
         begin
            rp_r <= rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ==== logic/seefe_ctl.sv ====
`timescale 1ns/1ps
`include "seefe_defs.svh"
// Controller end: runs one command per request, paced by a divided clock
module seefe_ctl
   import seefe_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   seefe_if.ctl bus,
   input wire logic [2:0] cmd_sel,
   input wire seefe_op_t cmd_op,
   input wire logic [12:0] cmd_addr,
   input wire logic [7:0] cmd_len,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [8:0] wr_data,
   input wire logic wr_valid,
   output logic wr_ready,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic done,
   output logic nacked
);
   typedef enum {S_IDLE, S_START, S_BIT, S_ACK, S_STOP, S_END} seefe_cst_t;
   seefe_cst_t st_r;
   logic [3:0] div_r;
   logic [1:0] ph_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   logic [2:0] idx_r;
   logic [7:0] left_r;
   logic rd_r;
   logic [2:0] sel_r;
   seefe_op_t op_r;
   logic [12:0] addr_r;
   logic sda_r;
   logic scl_r;
   logic [1:0] sda_sy_r;
   logic tick;
   logic [8:0] f_data;
   logic f_valid;
   logic f_pop;

   // Write bytes pass the buffer; an empty buffer at a byte boundary ends the write with STOP, not a stalled bus
   seefe_fifo #(.WIDTH(9), .DEPTH(`SEEFE_FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk), .srst(srst), .in_data(wr_data), .in_valid(wr_valid),
      .in_ready(wr_ready), .out_data(f_data), .out_valid(f_valid), .out_ready(f_pop));

   assign tick = (div_r == 4'(`SEEFE_HALF_DIV - 1));
   assign cmd_ready = (st_r == S_IDLE);
   // Every loaded data byte leaves the buffer once, as its last bit goes out,
   // so the final byte of a write never lingers into the next command
   assign f_pop = tick && st_r == S_BIT && ph_r == 2'd3 && bit_r == 4'd7 && idx_r >= 3'd3
      && op_r == SEEFE_OP_WRITE;
   assign bus.scl_o = scl_r;
   assign bus.scl_oe = ~scl_r;
   assign bus.sda_ctl_o = sda_r;
   assign bus.sda_ctl_oe = ~sda_r;

   // Quarter-bit tick from the divider
   always_ff @(posedge sys_clk)
   begin
      if (srst || st_r == S_IDLE)
         div_r <= '0;
      else if (tick)
         div_r <= '0;
      else
         div_r <= div_r + 1'b1;
   end

   // Sampled data line, two stages before use
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         sda_sy_r <= 2'b11;
      else
         sda_sy_r <= {sda_sy_r[0], bus.sda};
   end

   // Sequencer: phase 0 SCL low set data, 1 rise, 2 sample, 3 fall
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         st_r <= S_IDLE;
         {ph_r, bit_r, sh_r, idx_r, left_r, rd_r} <= '0;
         sel_r <= '0;
         op_r <= SEEFE_OP_WRITE;
         addr_r <= '0;
         sda_r <= 1'b1;
         scl_r <= 1'b1;
         rd_data <= '0;
         rd_valid <= 1'b0;
         done <= 1'b0;
         nacked <= 1'b0;
      end
      else
      begin
         rd_valid <= 1'b0;
         done <= 1'b0;
         unique case (st_r)
            S_IDLE:
            begin
               if (cmd_valid)
               begin
                  sel_r <= cmd_sel;
                  op_r <= cmd_op;
                  addr_r <= cmd_addr;
                  left_r <= cmd_len;
                  idx_r <= '0;
                  ph_r <= '0;
                  nacked <= 1'b0;
                  st_r <= S_START;
               end
            end
            S_START:
               if (tick)
               begin
                  // Data falls while the clock is high: START
                  if (ph_r == 2'd0)
                     sda_r <= 1'b0;
                  else if (ph_r == 2'd1)
                  begin
                     scl_r <= 1'b0;
                     sh_r <= {`SEEFE_TYPE_CODE, sel_r, op_r == SEEFE_OP_READ};
                     rd_r <= 1'b0;
                     bit_r <= '0;
                     st_r <= S_BIT;
                  end
                  ph_r <= (ph_r == 2'd1) ? 2'd0 : ph_r + 1'b1;
               end
            S_BIT:
               if (tick)
               begin
                  // Data moves only with the clock low, except START and STOP
                  if (ph_r == 2'd0)
                     sda_r <= rd_r ? 1'b1 : sh_r[7];
                  else if (ph_r == 2'd1)
                     scl_r <= 1'b1;
                  else if (ph_r == 2'd2)
                  begin
                     sh_r <= {sh_r[6:0], rd_r ? sda_sy_r[1] : 1'b0};
                  end
                  else
                  begin
                     scl_r <= 1'b0;
                     bit_r <= bit_r + 1'b1;
                     if (bit_r == 4'd7)
                        st_r <= S_ACK;
                  end
                  ph_r <= ph_r + 1'b1;
               end
            S_ACK:
               if (tick)
               begin
                  if (ph_r == 2'd0)
                     // Controller acks a read byte unless it is the last
                     sda_r <= rd_r ? (left_r == 8'h01) : 1'b1;
                  else if (ph_r == 2'd1)
                     scl_r <= 1'b1;
                  else if (ph_r == 2'd2)
                  begin
                     if (rd_r)
                     begin
                        rd_data <= sh_r;
                        rd_valid <= 1'b1;
                     end
                     else if (sda_sy_r[1])
                        nacked <= 1'b1;
                  end
                  else
                  begin
                     scl_r <= 1'b0;
                     bit_r <= '0;
                     idx_r <= (idx_r == 3'd7) ? idx_r : idx_r + 1'b1;
                     st_r <= S_BIT;
                     if (nacked)
                        st_r <= S_STOP;
                     else if (rd_r || op_r == SEEFE_OP_READ)
                     begin
                        rd_r <= 1'b1;
                        if (rd_r)
                           left_r <= left_r - 1'b1;
                        if (rd_r && left_r == 8'h01)
                           st_r <= S_STOP;
                     end
                     else if (idx_r == 3'd0)
                        sh_r <= {3'b000, addr_r[12:8]};
                     else if (idx_r == 3'd1)
                        sh_r <= addr_r[7:0];
                     else if (op_r == SEEFE_OP_SETADDR || left_r == 8'h00 || !f_valid)
                        st_r <= S_STOP;
                     else
                     begin
                        // Byte copied from the buffer head before its first bit; it is popped as its last bit goes out
                        sh_r <= f_data[7:0];
                        left_r <= left_r - 1'b1;
                     end
                  end
                  ph_r <= ph_r + 1'b1;
               end
            S_STOP:
               if (tick)
               begin
                  // Data rises while the clock is high: STOP
                  if (ph_r == 2'd0)
                     sda_r <= 1'b0;
                  else if (ph_r == 2'd1)
                     scl_r <= 1'b1;
                  else if (ph_r == 2'd2)
                     sda_r <= 1'b1;
                  else
                     st_r <= S_END;
                  ph_r <= ph_r + 1'b1;
               end
            S_END:
            begin
               done <= 1'b1;
               st_r <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// ==== logic/seefe_dev.sv ====
`timescale 1ns/1ps
`include "seefe_defs.svh"
// Operation
// - Sample on rising clock, drive after falling
// - Unconnected chip selects read as low
// - Data line driven open-drain only
// - Write-protect high blocks all programming
// - Reads ignore write-protect level
// - 256 pages of 32 bytes, 13-bit address
// - Controller changes data only while clock low
// - Data falling with clock high is START
// - Nothing counts as command without START
// - Data rising with clock high is STOP
// - STOP after read returns to standby
// - STOP after write starts timed programming
// - Programming finishes within five milliseconds
// - Eight-bit words, acknowledge on ninth clock
// - Standby after reset, read stop, programming
// - Address word top nibble is type code
// - Chip-select bits must match, else standby
// - Last address bit chooses read or write
// - Page writes up to 32, partial allowed
// - Two word-address bytes follow, each acknowledged
// - Page write increments low five bits only
// - No acknowledge while programming is busy
// - Address counter holds last access plus one
module seefe_dev
   import seefe_pkg::*;
#(
   parameter int TWR_CYC = `SEEFE_TWR_CYC
) (
   input wire logic sys_clk,
   input wire logic srst,
   seefe_if.dev bus,
   input wire logic [2:0] chip_select_pins,
   input wire logic write_protect,
   output logic busy,
   output logic standby
);
   typedef enum {D_IDLE, D_DEVADR, D_ADRH, D_ADRL, D_WDATA, D_RDATA, D_RACK} seefe_dst_t;
   localparam int PB = `SEEFE_PAGE_BITS;
   seefe_dst_t st_r;
   logic [7:0] mem [`SEEFE_MEM_DEPTH];
   logic [7:0] page_r [1 << PB];
   logic [(1 << PB)-1:0] dirty_r;
   logic [1:0] scl_sy_r;
   logic [1:0] sda_sy_r;
   logic [1:0] wp_sy_r;
   logic [2:0] cs_pre_r;
   logic [2:0] cs_sy_r;
   logic scl_d_r;
   logic sda_d_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   logic [12:0] cnt_r;
   logic drv_r;
   logic wrote_r;
   logic prot_r;
   logic [31:0] tmr_r;
   logic [PB:0] pidx_r;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   logic ninth;

   // Edges seen only after two-stage sampling of the pins
   assign scl_rise = scl_sy_r[1] & ~scl_d_r;
   assign scl_fall = ~scl_sy_r[1] & scl_d_r;
   assign start_ev = scl_sy_r[1] & scl_d_r & sda_d_r & ~sda_sy_r[1];
   assign stop_ev = scl_sy_r[1] & scl_d_r & ~sda_d_r & sda_sy_r[1];
   assign ninth = (bit_r == 4'd8);
   assign busy = (tmr_r != '0);
   assign standby = (st_r == D_IDLE) && !busy;
   assign bus.sda_dev_o = 1'b0;
   assign bus.sda_dev_oe = drv_r;

   // Pin synchronisers and delayed copies
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         scl_sy_r <= 2'b11;
         sda_sy_r <= 2'b11;
         wp_sy_r <= '0;
         cs_pre_r <= '0;
         cs_sy_r <= '0;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else
      begin
         scl_sy_r <= {scl_sy_r[0], bus.scl};
         sda_sy_r <= {sda_sy_r[0], bus.sda};
         wp_sy_r <= {wp_sy_r[0], write_protect};
         cs_pre_r <= chip_select_pins; // Straps tied low when open
         cs_sy_r <= cs_pre_r;
         scl_d_r <= scl_sy_r[1];
         sda_d_r <= sda_sy_r[1];
      end
   end

   // Self-timed programming: page buffer written out, then timer runs down
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         tmr_r <= '0;
      else if (stop_ev && wrote_r && !prot_r && dirty_r != '0)
         tmr_r <= 32'(TWR_CYC);
      else if (tmr_r != '0)
         tmr_r <= tmr_r - 1'b1;
   end

   // Array update at the STOP; only bytes received in this page are touched
   always_ff @(posedge sys_clk)
   begin
      if (stop_ev && wrote_r && !prot_r)
      begin
         for (int i = 0; i < (1 << PB); i++)
         begin
            if (dirty_r[i])
               mem[{cnt_r[12:PB], PB'(i)}] <= page_r[i];
         end
      end
   end

   // Protocol engine
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         st_r <= D_IDLE;
         bit_r <= '0;
         sh_r <= '0;
         cnt_r <= '0;
         drv_r <= 1'b0;
         wrote_r <= 1'b0;
         prot_r <= 1'b0;
         dirty_r <= '0;
         pidx_r <= '0;
      end
      else if (start_ev)
      begin
         // Any START begins a fresh address word
         st_r <= D_DEVADR;
         bit_r <= 4'hF; // The clock fall that follows START wraps this to 0
         drv_r <= 1'b0;
         wrote_r <= 1'b0;
         dirty_r <= '0;
         pidx_r <= '0;
      end
      else if (stop_ev)
      begin
         st_r <= D_IDLE;
         drv_r <= 1'b0;
         if (wrote_r && pidx_r != '0)
            cnt_r[PB-1:0] <= cnt_r[PB-1:0] + PB'(pidx_r);
      end
      else if (st_r != D_IDLE && scl_rise)
      begin
         // Sample on the rising edge
         if (!ninth)
            sh_r <= {sh_r[6:0], sda_sy_r[1]};
         else if (st_r == D_RACK && sda_sy_r[1])
            st_r <= D_IDLE; // Controller declined another byte
      end
      else if (st_r != D_IDLE && scl_fall)
      begin
         // Outputs change just after the falling edge
         drv_r <= 1'b0;
         bit_r <= ninth ? 4'd0 : bit_r + 1'b1;
         if (bit_r == 4'd7)
         begin
            unique case (st_r)
               D_DEVADR:
               begin
                  if (sh_r[7:4] != `SEEFE_TYPE_CODE || sh_r[3:1] != cs_sy_r || busy)
                  begin
                     st_r <= D_IDLE;
                  end
                  else
                  begin
                     drv_r <= 1'b1;
                     prot_r <= wp_sy_r[1];
                     st_r <= sh_r[0] ? D_RDATA : D_ADRH;
                  end
               end
               D_ADRH:
               begin
                  cnt_r[12:8] <= sh_r[4:0];
                  drv_r <= 1'b1;
                  st_r <= D_ADRL;
               end
               D_ADRL:
               begin
                  cnt_r[7:0] <= sh_r;
                  drv_r <= 1'b1;
                  st_r <= D_WDATA;
               end
               D_WDATA:
               begin
                  // Low five bits wrap in the page buffer
                  page_r[cnt_r[PB-1:0] + PB'(pidx_r)] <= sh_r;
                  dirty_r[cnt_r[PB-1:0] + PB'(pidx_r)] <= 1'b1;
                  pidx_r <= pidx_r + 1'b1;
                  wrote_r <= 1'b1;
                  drv_r <= 1'b1;
               end
               default:
               begin
                  // Read: release the line for the controller acknowledge
                  st_r <= D_RACK;
                  cnt_r <= cnt_r + 1'b1;
               end
            endcase
         end
         else if (ninth)
         begin
            if (st_r == D_RDATA || st_r == D_RACK)
            begin
               // Next read byte out, MSB first
               st_r <= D_RDATA;
               sh_r <= mem[cnt_r];
               drv_r <= ~mem[cnt_r][7];
            end
         end
         else if (st_r == D_RDATA)
         begin
            // Each rising edge has already shifted the next bit to the top
            drv_r <= ~sh_r[7];
         end
      end
   end
endmodule

// ==== testbench/seefe_asserts.sv ====
`timescale 1ns/1ps
// Watches the joined link and the status of the device on it
module seefe_asserts #(
   parameter int TWR_CYC = 200
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe,
   input wire logic busy,
   input wire logic standby
);
   logic [31:0] busy_cnt_r;
   logic [3:0] since_stop_r;
   logic scl_d_r;
   logic sda_d_r;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // Length of the running programming cycle
   always_ff @(posedge sys_clk)
      busy_cnt_r <= (srst || !busy) ? 32'h0 : busy_cnt_r + 32'h1;
   // Wire history for edge detection
   always_ff @(posedge sys_clk)
   begin
      scl_d_r <= scl;
      sda_d_r <= sda;
   end
   // Cycles since the last STOP; saturates so a stale STOP never counts
   always_ff @(posedge sys_clk)
      if (srst)
         since_stop_r <= 4'hF;
      else if (scl && scl_d_r && sda && !sda_d_r)
         since_stop_r <= 4'h0;
      else if (since_stop_r != 4'hF)
         since_stop_r <= since_stop_r + 4'h1;
   a_dev_open_drain: assert property (sda_dev_oe |-> !sda_dev_o)
      else $error("device drove the data line high");
   a_dev_change_low: assert property ($changed(sda_dev_oe) |-> !scl)
      else $error("device data changed while clock high");
   a_ack_hold: assert property ($rose(sda_dev_oe) |-> sda_dev_oe [*8])
      else $error("device low bit too short");
   a_busy_not_idle: assert property (busy |-> !standby)
      else $error("standby while programming");
   a_busy_bounded: assert property (busy_cnt_r <= TWR_CYC)
      else $error("programming cycle too long");
   a_busy_after_stop: assert property ($rose(busy) |-> since_stop_r <= 4'h8)
      else $error("programming began without a STOP");
   a_standby_quiet: assert property (standby |-> !sda_dev_oe)
      else $error("device drove the line in standby");
   a_busy_no_ack: assert property (busy |-> !sda_dev_oe)
      else $error("device answered while programming");
   cover property ($rose(busy));
   cover property ($fell(sda_dev_oe));
   cover property ($rose(standby));
endmodule

// ==== testbench/serial_eeprom_bus_front_end_test.sv ====
`timescale 1ns/1ps
// Controller and device share one link; a second device sits on a hand-driven link
module serial_eeprom_bus_front_end_test
   import seefe_pkg::*;
;
   // Long enough that a poll sent straight after a write still meets a busy device
   localparam int TWR = 400;
   logic sys_clk = 1'h0;
   logic srst = 1'h1;
   logic [2:0] cmd_sel = 3'h0;
   seefe_op_t cmd_op = SEEFE_OP_WRITE;
   logic [12:0] cmd_addr = 13'h0000;
   logic [7:0] cmd_len = 8'h00;
   logic cmd_valid = 1'h0;
   logic [8:0] wr_data = 9'h000;
   logic wr_valid = 1'h0;
   logic [2:0] chip_select_pins = 3'h0;
   logic write_protect = 1'h0;
   logic bb_scl_oe = 1'h0;
   logic bb_sda_oe = 1'h0;
   logic cmd_ready;
   logic wr_ready;
   logic [7:0] rd_data;
   logic rd_valid;
   logic done;
   logic nacked;
   logic busy;
   logic standby;
   logic [7:0] mem_m [0:8191];
   logic [7:0] rd_q [$];
   int err_count = 0;
   int n_compared = 0;
   seefe_if u_seefe_if();
   seefe_if u_seefe_if_b();
   // Hand-driven link only ever pulls low, as an open-drain controller would
   assign u_seefe_if_b.scl_o = 1'h0;
   assign u_seefe_if_b.scl_oe = bb_scl_oe;
   assign u_seefe_if_b.sda_ctl_o = 1'h0;
   assign u_seefe_if_b.sda_ctl_oe = bb_sda_oe;
   always #2 sys_clk = ~sys_clk;
   seefe_ctl u_seefe_ctl (.sys_clk(sys_clk), .srst(srst), .bus(u_seefe_if.ctl),
      .cmd_sel(cmd_sel), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .wr_data(wr_data),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
      .rd_valid(rd_valid), .done(done), .nacked(nacked));
   seefe_dev #(.TWR_CYC(TWR)) u_seefe_dev (.sys_clk(sys_clk), .srst(srst),
      .bus(u_seefe_if.dev), .chip_select_pins(chip_select_pins),
      .write_protect(write_protect), .busy(busy), .standby(standby));
   // Second device has its select pins tied to 3'h0, as open pins must read
   seefe_dev #(.TWR_CYC(TWR)) u_seefe_dev_b (.sys_clk(sys_clk), .srst(srst),
      .bus(u_seefe_if_b.dev), .chip_select_pins(3'h0), .write_protect(1'h0),
      .busy(), .standby());
   seefe_asserts #(.TWR_CYC(TWR)) u_seefe_asserts (.sys_clk(sys_clk), .srst(srst),
      .scl(u_seefe_if.scl), .sda(u_seefe_if.sda), .sda_dev_o(u_seefe_if.sda_dev_o),
      .sda_dev_oe(u_seefe_if.sda_dev_oe), .busy(busy), .standby(standby));
   task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic chk1(input logic exp, input logic got);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // A wait that ran out ends the run at once
   task automatic lim();
      chk1(1'h1, 1'h0);
      summarize();
   endtask
   // One command, held until taken, then reads gathered until done
   task automatic run_cmd(input seefe_op_t op, input logic [12:0] addr, input logic [7:0] len);
      int i;
      rd_q.delete();
      cmd_op = op;
      cmd_addr = addr;
      cmd_len = len;
      cmd_valid = 1'h1;
      for (i = 0; i < 50 && !cmd_ready; i++)
         @(negedge sys_clk);
      if (!cmd_ready)
         lim();
      @(negedge sys_clk);
      cmd_valid = 1'h0;
      for (i = 0; i < 20000 && !done; i++)
      begin
         @(negedge sys_clk);
         if (rd_valid)
            rd_q.push_back(rd_data);
      end
      if (!done)
         lim();
   endtask
   // Leaves valid high so back-to-back pushes never toggle it in one step
   task automatic push(input logic [7:0] d);
      int i;
      wr_data = {1'h0, d};
      wr_valid = 1'h1;
      for (i = 0; i < 100 && !wr_ready; i++)
         @(negedge sys_clk);
      if (!wr_ready)
         lim();
      @(negedge sys_clk);
   endtask
   task automatic write_bytes(input logic [12:0] addr, input int n, input logic [7:0] base);
      int k;
      for (k = 0; k < n; k++)
         push(base + 8'(k));
      if (n == 32)
         chk1(1'h0, wr_ready);
      wr_valid = 1'h0;
      run_cmd(SEEFE_OP_WRITE, addr, 8'(n));
      chk1(1'h0, nacked);
      chk1(!write_protect, busy);
      for (k = 0; k < n && !write_protect; k++)
         mem_m[{addr[12:5], addr[4:0] + 5'(k)}] = base + 8'(k);
   endtask
   task automatic wait_idle();
      int i;
      for (i = 0; i < TWR + 20 && !standby; i++)
         @(negedge sys_clk);
      if (!standby)
         lim();
   endtask
   task automatic read_check(input logic [12:0] addr, input int n);
      int k;
      run_cmd(SEEFE_OP_SETADDR, addr, 8'h00);
      chk1(1'h0, nacked);
      run_cmd(SEEFE_OP_READ, addr, 8'(n));
      chk1(1'h0, nacked);
      chk8(8'(n), 8'(rd_q.size()));
      for (k = 0; k < n && k < rd_q.size(); k++)
         chk8(mem_m[13'(addr + 13'(k))], rd_q[k]);
      chk1(1'h1, standby);
   endtask
   task automatic s_page();
      write_bytes(13'h0040, 32, 8'h10);
      wait_idle();
      read_check(13'h0040, 32);
   endtask
   task automatic s_wrap();
      write_bytes(13'h1FFE, 3, 8'hC0);
      wait_idle();
      read_check(13'h1FFE, 2);
      read_check(13'h1FE0, 1);
   endtask
   task automatic s_protect();
      write_protect = 1'h1;
      write_bytes(13'h0041, 1, 8'h77);
      read_check(13'h0041, 1);
      write_protect = 1'h0;
   endtask
   task automatic s_select();
      chip_select_pins = 3'h5;
      run_cmd(SEEFE_OP_READ, 13'h0000, 8'h01);
      chk1(1'h1, nacked);
      cmd_sel = 3'h5;
      read_check(13'h0040, 1);
      chip_select_pins = 3'h0;
      cmd_sel = 3'h0;
   endtask
   task automatic s_poll();
      write_bytes(13'h0100, 1, 8'h5A);
      run_cmd(SEEFE_OP_SETADDR, 13'h0100, 8'h00);
      chk1(1'h1, nacked);
      wait_idle();
      read_check(13'h0100, 1);
   endtask
   // Half a 48 ns link period; data moves only once the clock has settled
   task automatic bb_half(input logic scl_low, input logic sda_low);
      bb_scl_oe = scl_low;
      repeat (3) @(negedge sys_clk);
      bb_sda_oe = sda_low;
      repeat (3) @(negedge sys_clk);
   endtask
   task automatic bb_byte(input logic [7:0] b, output logic ack);
      int k;
      for (k = 7; k >= 0; k--)
      begin
         bb_half(1'h1, !b[k]);
         bb_half(1'h0, !b[k]);
      end
      bb_half(1'h1, 1'h0);
      bb_half(1'h0, 1'h0);
      ack = !u_seefe_if_b.sda;
   endtask
   task automatic s_raw_link();
      logic ack;
      bb_half(1'h1, 1'h0);
      bb_byte(8'hA0, ack);
      chk1(1'h0, ack);
      bb_half(1'h0, 1'h1);
      bb_byte(8'hA0, ack);
      chk1(1'h1, ack);
      bb_half(1'h1, 1'h1);
      bb_half(1'h0, 1'h1);
      bb_half(1'h0, 1'h0);
      bb_half(1'h0, 1'h1);
      bb_byte(8'hB0, ack);
      chk1(1'h0, ack);
      bb_half(1'h1, 1'h1);
      bb_half(1'h0, 1'h1);
      bb_half(1'h0, 1'h0);
   endtask
   // Main sequence
   initial
   begin
      repeat (2) @(negedge sys_clk);
      srst = 1'h0;
      chk1(1'h1, standby);
      s_page();
      s_wrap();
      s_protect();
      s_select();
      s_poll();
      s_raw_link();
      summarize();
   end
endmodule
